// >>> rtl/sideband_user_end.sv
// User application end: AXI4-Lite registers drive the sideband orders and
// report reset progress, with a maskable level interrupt.
// Assumes a single AXI4-Lite master on aclk.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "sideband_cfg.svh"

module sideband_user_end (
  // Link to the core
  sideband_if.user_end sb,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q, irq_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [`SB_CTRL_L23:0] ctrl_q;
  logic [31:0] id_q [`SB_ID_FIRST:`SB_ID_LAST];
  logic uncor_q, vf_done_q;
  logic [7:0] vf_num_q;
  logic [`SB_PF_COUNT-1:0] pf_done_q, pf_prev_q;
  logic vf_prev_q;
  logic [`SB_EV_W-1:0] status_q, mask_q;
  logic [31:0] rd_mux;

  wire aw_fire = s_axi_awvalid && awready_q;
  wire w_fire = s_axi_wvalid && wready_q;
  wire ar_fire = s_axi_arvalid && arready_q;
  wire do_write = aw_have_q && w_have_q && !bvalid_q;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire [31:0] wbits = w_data_q & wmask;
  wire [2:0] w_word = aw_addr_q[4:2];
  wire w_is_id = (aw_addr_q >= `SB_REG_VENDOR) && (aw_addr_q <= `SB_REG_REVISION);
  wire w_ctrl = do_write && aw_addr_q == `SB_REG_CTRL;
  wire w_flr = do_write && aw_addr_q == `SB_REG_FLR;
  wire w_vf = do_write && aw_addr_q == `SB_REG_VF_DONE;
  wire w_stat = do_write && aw_addr_q == `SB_REG_IRQ_STATUS;
  wire w_mask = do_write && aw_addr_q == `SB_REG_IRQ_MASK;
  wire w_mapped = w_is_id || w_ctrl || w_flr || w_vf || w_stat || w_mask;
  wire [7:0] ra = s_axi_araddr;
  wire r_is_id = (ra >= `SB_REG_VENDOR) && (ra <= `SB_REG_REVISION);
  wire r_mapped = r_is_id || ra == `SB_REG_CTRL || ra == `SB_REG_FLR || ra == `SB_REG_VF_DONE
                  || ra == `SB_REG_IRQ_STATUS || ra == `SB_REG_IRQ_MASK;

  // Events: any physical function entering reset, or a virtual function entering reset while none was busy
  wire vf_any = |sb.vf_reset_in_progress;
  wire [`SB_EV_W-1:0] events = {vf_any && !vf_prev_q, |(sb.pf_reset_in_progress & ~pf_prev_q)};
  wire [`SB_EV_W-1:0] w1c = w_stat ? wbits[`SB_EV_W-1:0] : '0;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (r_is_id) begin
      rd_mux = id_q[ra[4:2]];
    end else if (ra == `SB_REG_CTRL) begin
      rd_mux[`SB_CTRL_L23:0] = ctrl_q;
    end else if (ra == `SB_REG_FLR) begin
      rd_mux[`SB_PF_COUNT-1:0] = sb.pf_reset_in_progress;
    end else if (ra == `SB_REG_VF_DONE) begin
      rd_mux[7:0] = sb.bus_number;
    end else if (ra == `SB_REG_IRQ_STATUS) begin
      rd_mux[`SB_EV_W-1:0] = status_q;
    end else if (ra == `SB_REG_IRQ_MASK) begin
      rd_mux[`SB_EV_W-1:0] = mask_q;
    end
  end

  // Bus handshakes: one write and one read in flight
  always_ff @(posedge sb.aclk) begin
    if (!sb.aresetn) begin
      {awready_q, wready_q, arready_q} <= 3'h7;
      {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= 4'h0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bresp_q <= `SB_RESP_OKAY;
      rresp_q <= `SB_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (aw_fire) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        {aw_have_q, w_have_q} <= 2'h0;
        bvalid_q <= 1'b1;
        bresp_q <= w_mapped ? `SB_RESP_OKAY : `SB_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        {awready_q, wready_q} <= 2'h3;
      end
      if (ar_fire) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= r_mapped ? `SB_RESP_OKAY : `SB_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // Register effects; pulse orders last exactly one cycle
  always_ff @(posedge sb.aclk) begin
    if (!sb.aresetn) begin
      ctrl_q <= '0;
      for (int i = `SB_ID_FIRST; i <= `SB_ID_LAST; i++) begin
        id_q[i] <= `SB_WORD_RESET;
      end
      uncor_q <= 1'b0;
      pf_done_q <= '0;
      vf_done_q <= 1'b0;
      vf_num_q <= 8'h00;
      pf_prev_q <= '0;
      vf_prev_q <= 1'b0;
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      // Software must have all functions in D3 and the turn-off acked first
      if (w_ctrl) begin
        ctrl_q <= (ctrl_q & ~wmask[`SB_CTRL_L23:0]) | wbits[`SB_CTRL_L23:0];
      end
      if (do_write && w_is_id) begin
        id_q[w_word] <= (id_q[w_word] & ~wmask) | wbits;
      end
      // Software should also read the error registers; this pulse can be lost
      uncor_q <= w_ctrl && wbits[`SB_CTRL_UNCOR];
      pf_done_q <= w_flr ? wbits[`SB_PF_COUNT-1:0] : '0;
      // Reserved function numbers are dropped, never sent
      vf_done_q <= w_vf && (wbits[7:0] >= `SB_VF_BASE);
      if (w_vf) begin
        vf_num_q <= wbits[7:0];
      end
      pf_prev_q <= sb.pf_reset_in_progress;
      vf_prev_q <= vf_any;
      status_q <= (status_q & ~w1c) | events;
      if (w_mask) begin
        mask_q <= wbits[`SB_EV_W-1:0];
      end
      irq_q <= |(((status_q & ~w1c) | events) & (w_mask ? wbits[`SB_EV_W-1:0] : mask_q));
    end
  end

  assign sb.uncorrectable_internal_error = uncor_q;
  assign sb.pf_reset_complete = pf_done_q;
  assign sb.vf_reset_complete = vf_done_q;
  assign sb.vf_reset_function_number = vf_num_q;
  assign sb.link_training_enable = ctrl_q[`SB_CTRL_TRAIN];
  assign sb.request_l23_ready = ctrl_q[`SB_CTRL_L23];
  assign sb.vendor_identifier_in = id_q[`SB_ID_VENDOR][15:0];
  assign sb.subsystem_vendor_identifier_in = id_q[`SB_ID_VENDOR][31:16];
  generate
    for (genvar g = 0; g < `SB_PF_COUNT; g++) begin : g_pf
      assign sb.device_identifier_function[g] = id_q[`SB_ID_PF0 + g][15:0];
      assign sb.subsystem_identifier_function[g] = id_q[`SB_ID_PF0 + g][31:16];
      assign sb.revision_identifier_function[g] = id_q[`SB_ID_REVISION][8*g +: 8];
    end
  endgenerate
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign irq = irq_q;

endmodule : sideband_user_end

`default_nettype wire

// >>> include/sideband_cfg.svh
// Constants shared by both ends of the configuration sideband.
// Assumes it is included by bare name after the package.
`ifndef SIDEBAND_CFG_SVH
`define SIDEBAND_CFG_SVH

`define SB_PF_COUNT 4
`define SB_VF_COUNT 252
`define SB_VF_BASE 8'h04
`define SB_VF_IDX_W 8

// User-end register byte offsets (AXI4-Lite, one word each)
`define SB_REG_CTRL 8'h00
`define SB_REG_VENDOR 8'h04
`define SB_REG_PF_ID0 8'h08
`define SB_REG_PF_ID3 8'h14
`define SB_REG_REVISION 8'h18
`define SB_REG_FLR 8'h1C
`define SB_REG_VF_DONE 8'h20
`define SB_REG_IRQ_STATUS 8'h24
`define SB_REG_IRQ_MASK 8'h28

// Word indices of the identification words
`define SB_ID_FIRST 3'h1
`define SB_ID_LAST 3'h6
`define SB_ID_VENDOR 3'h1
`define SB_ID_PF0 3'h2
`define SB_ID_REVISION 3'h6

// Control register bits
`define SB_CTRL_TRAIN 0
`define SB_CTRL_L23 1
`define SB_CTRL_UNCOR 2

// Interrupt status bits
`define SB_EV_PF_FLR 0
`define SB_EV_VF_FLR 1
`define SB_EV_W 2

`define SB_WORD_RESET 32'h0000_0000
`define SB_RESP_OKAY 2'h0
`define SB_RESP_SLVERR 2'h2

`endif

// >>> include/sideband_pkg.sv
// Types used by the core end of the configuration sideband and by the bench.
// Assumes nothing beyond a SystemVerilog compiler.
package sideband_pkg;

  typedef enum logic [1:0] {
    LINK_QUIET = 2'h0,
    LINK_UP = 2'h1,
    LINK_L23 = 2'h3,
    LINK_L3 = 2'h2
  } link_state_e;

  typedef struct packed {
    logic [15:0] vendor;
    logic [15:0] device;
    logic [7:0] revision;
    logic [15:0] subsys_vendor;
    logic [15:0] subsys;
  } pf_header_s;

endpackage : sideband_pkg

// >>> include/sideband_if.sv
// Sideband wires between the core end and the user application end.
// Assumes both ends share aclk and the synchronous aresetn.
`timescale 1ns/100ps
`default_nettype none
`include "sideband_cfg.svh"

interface sideband_if (
  input wire logic aclk,
  input wire logic aresetn
);
  logic uncorrectable_internal_error;
  logic [`SB_PF_COUNT-1:0] pf_reset_in_progress;
  logic [`SB_PF_COUNT-1:0] pf_reset_complete;
  logic [`SB_VF_COUNT-1:0] vf_reset_in_progress;
  logic vf_reset_complete;
  logic [7:0] vf_reset_function_number;
  logic request_l23_ready;
  logic link_training_enable;
  logic [7:0] bus_number;
  logic [15:0] vendor_identifier_in;
  logic [15:0] subsystem_vendor_identifier_in;
  logic [`SB_PF_COUNT-1:0][15:0] device_identifier_function;
  logic [`SB_PF_COUNT-1:0][7:0] revision_identifier_function;
  logic [`SB_PF_COUNT-1:0][15:0] subsystem_identifier_function;

  modport core_end (
    input aclk, aresetn,
    input uncorrectable_internal_error, pf_reset_complete, vf_reset_complete,
    input vf_reset_function_number, request_l23_ready, link_training_enable,
    input vendor_identifier_in, subsystem_vendor_identifier_in,
    input device_identifier_function, revision_identifier_function,
    input subsystem_identifier_function,
    output pf_reset_in_progress, vf_reset_in_progress, bus_number
  );

  modport user_end (
    input aclk, aresetn,
    output uncorrectable_internal_error, pf_reset_complete, vf_reset_complete,
    output vf_reset_function_number, request_l23_ready, link_training_enable,
    output vendor_identifier_in, subsystem_vendor_identifier_in,
    output device_identifier_function, revision_identifier_function,
    output subsystem_identifier_function,
    input pf_reset_in_progress, vf_reset_in_progress, bus_number
  );
endinterface : sideband_if

`default_nettype wire

// >>> rtl/sideband_core_end.sv
// Core end of the configuration sideband: function reset tracking, retry
// answers, internal error status, link gating, bus capture, header loading.
// Assumes the host-side events arrive as one-cycle pulses on aclk.
`timescale 1ns/100ps
`default_nettype none
`include "sideband_cfg.svh"

module sideband_core_end (
  // Link to the user application
  sideband_if.core_end sb,
  // Mode and enables
  input wire logic endpoint_mode,
  input wire logic [`SB_PF_COUNT-1:0] function_enabled,
  input wire logic error_message_enable,
  // Host function reset requests
  input wire logic [`SB_PF_COUNT-1:0] host_pf_reset_set,
  input wire logic host_vf_reset_set,
  input wire logic [7:0] host_vf_reset_number,
  // Error status clear from configuration writes
  input wire logic [`SB_PF_COUNT-1:0] aer_status_clear,
  // Configuration requests
  input wire logic cfg_req_valid,
  input wire logic [7:0] cfg_req_function,
  input wire logic cfg_req_type0_write,
  input wire logic [7:0] cfg_req_bus,
  // Answers and state
  output logic cfg_req_done,
  output logic cfg_req_retry,
  output logic [`SB_PF_COUNT-1:0] aer_internal_error,
  output logic error_message_sent,
  output sideband_pkg::link_state_e link_state,
  output sideband_pkg::pf_header_s [`SB_PF_COUNT-1:0] pf_header
);

  logic [`SB_PF_COUNT-1:0] pf_prog_q;
  logic [`SB_PF_COUNT-1:0] pf_prog_d;
  logic [`SB_VF_COUNT-1:0] vf_prog_q;
  logic [`SB_VF_COUNT-1:0] vf_prog_d;
  logic [`SB_VF_COUNT-1:0] vf_set;
  logic [`SB_VF_COUNT-1:0] vf_clear;
  logic [`SB_PF_COUNT-1:0] aer_q;
  logic [`SB_PF_COUNT-1:0] aer_d;
  logic err_msg_q;
  logic done_q;
  logic retry_q;
  logic retry_d;
  logic [7:0] bus_q;
  sideband_pkg::link_state_e link_q;
  sideband_pkg::link_state_e link_d;
  sideband_pkg::pf_header_s [`SB_PF_COUNT-1:0] hdr_q;
  sideband_pkg::pf_header_s [`SB_PF_COUNT-1:0] hdr_d;

  // Function number decode
  wire req_is_vf = cfg_req_function >= `SB_VF_BASE;
  wire [7:0] req_vf_idx = cfg_req_function - `SB_VF_BASE;
  wire [1:0] req_pf_idx = cfg_req_function[1:0];
  wire vf_done_ok = sb.vf_reset_complete && (sb.vf_reset_function_number >= `SB_VF_BASE);
  wire [7:0] done_vf_idx = sb.vf_reset_function_number - `SB_VF_BASE;
  wire set_ok = host_vf_reset_set && (host_vf_reset_number >= `SB_VF_BASE);
  wire [7:0] set_vf_idx = host_vf_reset_number - `SB_VF_BASE;
  wire done_hits_req = vf_done_ok && (sb.vf_reset_function_number == cfg_req_function);

  // One-hot set and clear masks; reserved numbers below SB_VF_BASE give an empty mask
  assign vf_set = set_ok ? (`SB_VF_COUNT'(1) << set_vf_idx) : '0;
  assign vf_clear = vf_done_ok ? (`SB_VF_COUNT'(1) << done_vf_idx) : '0;

  // A fresh reset request wins over a done seen in the same cycle
  assign pf_prog_d = (pf_prog_q & ~sb.pf_reset_complete) | host_pf_reset_set;
  assign vf_prog_d = (vf_prog_q & ~vf_clear) | vf_set;

  // Retry while in progress and done not yet asserted
  assign retry_d = req_is_vf
                   ? (vf_prog_q[req_vf_idx] && !done_hits_req)
                   : (pf_prog_q[req_pf_idx] && !sb.pf_reset_complete[req_pf_idx]);

  // Error is not tied to a function: every enabled one records it
  assign aer_d = (aer_q & ~aer_status_clear)
                 | ({`SB_PF_COUNT{sb.uncorrectable_internal_error}} & function_enabled);

  // Link gating; L3 is left only by reset
  always_comb begin
    link_d = link_q;
    unique case (link_q)
      sideband_pkg::LINK_QUIET: begin
        if (sb.link_training_enable) begin
          link_d = sideband_pkg::LINK_UP;
        end
      end
      sideband_pkg::LINK_UP: begin
        if (!sb.link_training_enable) begin
          link_d = sideband_pkg::LINK_QUIET;
        end else if (sb.request_l23_ready && endpoint_mode) begin
          link_d = sideband_pkg::LINK_L23;
        end
      end
      sideband_pkg::LINK_L23: begin
        link_d = sideband_pkg::LINK_L3;
      end
      sideband_pkg::LINK_L3: begin
        link_d = sideband_pkg::LINK_L3;
      end
    endcase
  end

  // Header fields follow the inputs one cycle later
  always_comb begin
    for (int i = 0; i < `SB_PF_COUNT; i++) begin
      hdr_d[i].vendor = sb.vendor_identifier_in;
      hdr_d[i].subsys_vendor = sb.subsystem_vendor_identifier_in;
      hdr_d[i].device = sb.device_identifier_function[i];
      hdr_d[i].revision = sb.revision_identifier_function[i];
      hdr_d[i].subsys = sb.subsystem_identifier_function[i];
    end
  end

  always_ff @(posedge sb.aclk) begin
    if (!sb.aresetn) begin
      pf_prog_q <= '0;
      vf_prog_q <= '0;
      aer_q <= '0;
      err_msg_q <= 1'b0;
      done_q <= 1'b0;
      retry_q <= 1'b0;
      link_q <= sideband_pkg::LINK_QUIET;
      hdr_q <= '0;
    end else begin
      pf_prog_q <= pf_prog_d;
      vf_prog_q <= vf_prog_d;
      aer_q <= aer_d;
      // One message per event, only when some function can carry it
      err_msg_q <= sb.uncorrectable_internal_error && error_message_enable
                   && (|function_enabled);
      done_q <= cfg_req_valid;
      retry_q <= cfg_req_valid && retry_d;
      link_q <= link_d;
      hdr_q <= hdr_d;
    end
  end

  // Root mode never captures, so the output keeps its reset or last endpoint-mode value
  always_ff @(posedge sb.aclk) begin
    if (!sb.aresetn) begin
      bus_q <= 8'h00;
    end else if (cfg_req_valid && cfg_req_type0_write && endpoint_mode) begin
      bus_q <= cfg_req_bus;
    end
  end

  assign sb.pf_reset_in_progress = pf_prog_q;
  assign sb.vf_reset_in_progress = vf_prog_q;
  assign sb.bus_number = bus_q;
  assign cfg_req_done = done_q;
  assign cfg_req_retry = retry_q;
  assign aer_internal_error = aer_q;
  assign error_message_sent = err_msg_q;
  assign link_state = link_q;
  assign pf_header = hdr_q;

endmodule : sideband_core_end

`default_nettype wire

// >>> verification/sideband_sva.sv
// Checker for the sideband wires joining the core end and the user end.
// Assumes it sits beside the interface and sees its signals as inputs.
`timescale 1ns/100ps
`default_nettype none
`include "sideband_cfg.svh"

module sideband_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // User end to core end
  input wire logic uncorrectable_internal_error,
  input wire logic [`SB_PF_COUNT-1:0] pf_reset_complete,
  input wire logic vf_reset_complete,
  input wire logic [7:0] vf_reset_function_number,
  // Core end to user end
  input wire logic [`SB_PF_COUNT-1:0] pf_reset_in_progress,
  input wire logic [`SB_VF_COUNT-1:0] vf_reset_in_progress,
  input wire logic [7:0] bus_number
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  localparam logic [`SB_VF_COUNT-1:0] vf_one = 1;

  uncor_pulse_a: assert property (
    uncorrectable_internal_error |=> !uncorrectable_internal_error)
    else $error("internal error pulse lasted more than one cycle");
  pf_done_pulse_a: assert property (
    (|pf_reset_complete) |=> (pf_reset_complete == '0))
    else $error("function reset done pulse lasted more than one cycle");
  vf_done_pulse_a: assert property (
    vf_reset_complete |=> !vf_reset_complete)
    else $error("virtual reset done pulse lasted more than one cycle");
  vf_number_valid_a: assert property (
    vf_reset_complete |-> (vf_reset_function_number >= `SB_VF_BASE))
    else $error("virtual reset done sent with a reserved number");
  pf_clear_cause_a: assert property (
    (|($past(pf_reset_in_progress) & ~pf_reset_in_progress)) |->
    (($past(pf_reset_in_progress) & ~pf_reset_in_progress & ~$past(pf_reset_complete)) == '0))
    else $error("function reset busy bit dropped without its done bit");
  vf_clear_cause_a: assert property (
    (|($past(vf_reset_in_progress) & ~vf_reset_in_progress)) |-> $past(vf_reset_complete) &&
    (($past(vf_reset_in_progress) & ~vf_reset_in_progress) ==
    (vf_one << ($past(vf_reset_function_number) - `SB_VF_BASE))))
    else $error("virtual reset busy bit dropped for the wrong function");
  pf_done_clears_a: assert property (
    (|(pf_reset_complete & pf_reset_in_progress)) |=>
    ((pf_reset_in_progress & $past(pf_reset_complete) & $past(pf_reset_in_progress)) == '0))
    else $error("function reset busy bit still high after done");
  reset_quiet_a: assert property (
    $rose(aresetn) |-> (pf_reset_in_progress == '0) && (vf_reset_in_progress == '0) &&
    (bus_number == 8'h00))
    else $error("core outputs not cleared after reset");

  cover property (|pf_reset_in_progress);
  cover property (vf_reset_complete);
  cover property (uncorrectable_internal_error);
endmodule : sideband_sva

`default_nettype wire

// >>> verification/tb_top.sv
// Bench joining both sideband ends; software orders arrive over AXI4-Lite.
// Assumes the package, header and interface are compiled beforehand.
`timescale 1ns/100ps
`default_nettype none
`include "sideband_cfg.svh"

module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic endpoint_mode = 1'b1;
  logic [3:0] function_enabled = 4'h5;
  logic [3:0] host_pf_reset_set = 4'h0, aer_status_clear = 4'h0;
  logic host_vf_reset_set = 1'b0;
  logic [7:0] host_vf_reset_number = 8'h00;
  logic cfg_req_valid = 1'b0, cfg_req_type0_write = 1'b0, error_message_enable = 1'b1;
  logic [7:0] cfg_req_function = 8'h00;
  logic [7:0] cfg_req_bus = 8'h00;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, cfg_req_done, cfg_req_retry, msg_sent;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] aer_internal_error, pf_busy;
  logic [`SB_VF_COUNT-1:0] vf_busy;
  sideband_pkg::link_state_e link_state;
  sideband_pkg::pf_header_s [3:0] pf_header;
  int miscompares = 0, checks = 0;
  int msg_count = 0;
  int k;

  always #5 aclk = ~aclk;
  always @(posedge aclk) if (msg_sent === 1'b1) msg_count <= msg_count + 1;

  sideband_if sideband_if_inst (.aclk(aclk), .aresetn(aresetn));
  assign pf_busy = sideband_if_inst.pf_reset_in_progress;
  assign vf_busy = sideband_if_inst.vf_reset_in_progress;

  sideband_core_end sideband_core_end_inst (.sb(sideband_if_inst),
    .endpoint_mode(endpoint_mode), .function_enabled(function_enabled),
    .error_message_enable(error_message_enable), .host_pf_reset_set(host_pf_reset_set),
    .host_vf_reset_set(host_vf_reset_set), .host_vf_reset_number(host_vf_reset_number),
    .aer_status_clear(aer_status_clear), .cfg_req_valid(cfg_req_valid),
    .cfg_req_function(cfg_req_function), .cfg_req_type0_write(cfg_req_type0_write),
    .cfg_req_bus(cfg_req_bus), .cfg_req_done(cfg_req_done), .cfg_req_retry(cfg_req_retry),
    .aer_internal_error(aer_internal_error), .error_message_sent(msg_sent),
    .link_state(link_state), .pf_header(pf_header));

  sideband_user_end sideband_user_end_inst (.sb(sideband_if_inst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  sideband_sva sideband_sva_inst (.aclk(aclk), .aresetn(aresetn),
    .uncorrectable_internal_error(sideband_if_inst.uncorrectable_internal_error),
    .pf_reset_complete(sideband_if_inst.pf_reset_complete),
    .vf_reset_complete(sideband_if_inst.vf_reset_complete),
    .vf_reset_function_number(sideband_if_inst.vf_reset_function_number),
    .pf_reset_in_progress(pf_busy), .vf_reset_in_progress(vf_busy),
    .bus_number(sideband_if_inst.bus_number));

  task give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task hang(input string what);
    miscompares++;
    $display("BAD %s expected an answer seen none", what);
    give_verdict();
  endtask : hang

  task cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask : cycles

  // Address and data are offered together and each dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) hang("bvalid");
    cmp_word("bresp", 32'(er), 32'(r));
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) hang("rvalid");
    cmp_word("rresp", 32'(er), 32'(r));
    cmp_word("rdata", ed, d);
  endtask : rd

  task cfg(input logic [7:0] f, input logic t0, input logic [7:0] b, input logic er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    cfg_req_valid <= 1'b1;
    cfg_req_function <= f;
    cfg_req_type0_write <= t0;
    cfg_req_bus <= b;
    @(posedge aclk);
    cfg_req_valid <= 1'b0;
    for (int n = 0; n < 10 && !got; n++) begin
      @(posedge aclk);
      if (cfg_req_done === 1'b1) begin
        got = 1'b1;
        cmp_word("retry", 32'(er), 32'(cfg_req_retry));
      end
    end
    if (!got) hang("cfg_req_done");
  endtask : cfg

  initial begin
    cycles(12);
    aresetn <= 1'b1;
    rd(`SB_REG_CTRL, 32'h0, `SB_RESP_OKAY);
    rd(8'h40, 32'h0, `SB_RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, `SB_RESP_SLVERR);
    cmp_word("link", 32'(sideband_pkg::LINK_QUIET), 32'(link_state));
    $display("test reset and map done");
    wr(`SB_REG_VENDOR, 32'hA5C3_1E2D, `SB_RESP_OKAY);
    for (k = 0; k < 4; k++) wr(`SB_REG_PF_ID0 + 8'(4 * k), 32'h5000_1000 + 32'(k * 32'h1_0001), `SB_RESP_OKAY);
    wr(`SB_REG_REVISION, 32'h4433_2211, `SB_RESP_OKAY);
    cycles(3);
    for (k = 0; k < 4; k++) begin
      cmp_word("vendor", 32'h1E2D, 32'(pf_header[k].vendor));
      cmp_word("subsys_vendor", 32'hA5C3, 32'(pf_header[k].subsys_vendor));
      cmp_word("device", 32'h1000 + 32'(k), 32'(pf_header[k].device));
      cmp_word("revision", 32'(8'h11 * (k + 1)), 32'(pf_header[k].revision));
      cmp_word("subsys", 32'h5000 + 32'(k), 32'(pf_header[k].subsys));
    end
    $display("test identifiers done");
    wr(`SB_REG_CTRL, 32'h2, `SB_RESP_OKAY);
    cycles(4);
    cmp_word("link", 32'(sideband_pkg::LINK_QUIET), 32'(link_state));
    endpoint_mode <= 1'b0;
    wr(`SB_REG_CTRL, 32'h3, `SB_RESP_OKAY);
    cycles(5);
    cmp_word("link", 32'(sideband_pkg::LINK_UP), 32'(link_state));
    endpoint_mode <= 1'b1;
    cycles(6);
    cmp_word("link", 32'(sideband_pkg::LINK_L3), 32'(link_state));
    wr(`SB_REG_CTRL, 32'h1, `SB_RESP_OKAY);
    cycles(3);
    cmp_word("link", 32'(sideband_pkg::LINK_L3), 32'(link_state));
    aresetn <= 1'b0;
    cycles(12);
    aresetn <= 1'b1;
    cycles(2);
    cmp_word("link", 32'(sideband_pkg::LINK_QUIET), 32'(link_state));
    rd(`SB_REG_VENDOR, 32'h0, `SB_RESP_OKAY);
    $display("test link done");
    wr(`SB_REG_IRQ_MASK, 32'h3, `SB_RESP_OKAY);
    host_pf_reset_set <= 4'h2;
    @(posedge aclk) host_pf_reset_set <= 4'h0;
    cycles(3);
    cmp_word("pf_busy", 32'h2, 32'(pf_busy));
    rd(`SB_REG_IRQ_STATUS, 32'h1, `SB_RESP_OKAY);
    cmp_word("irq", 32'h1, 32'(irq));
    cfg(8'h01, 1'b1, 8'h3C, 1'b1);
    cfg(8'h00, 1'b0, 8'h00, 1'b0);
    rd(`SB_REG_VF_DONE, 32'h3C, `SB_RESP_OKAY);
    wr(`SB_REG_IRQ_MASK, 32'h0, `SB_RESP_OKAY);
    cycles(2);
    cmp_word("irq", 32'h0, 32'(irq));
    wr(`SB_REG_FLR, 32'h2, `SB_RESP_OKAY);
    cycles(3);
    cmp_word("pf_busy", 32'h0, 32'(pf_busy));
    cfg(8'h01, 1'b0, 8'h00, 1'b0);
    wr(`SB_REG_IRQ_STATUS, 32'h1, `SB_RESP_OKAY);
    rd(`SB_REG_IRQ_STATUS, 32'h0, `SB_RESP_OKAY);
    $display("test physical reset done");
    host_vf_reset_set <= 1'b1;
    host_vf_reset_number <= 8'h04;
    @(posedge aclk) host_vf_reset_number <= 8'hFF;
    @(posedge aclk) host_vf_reset_number <= 8'h03;
    @(posedge aclk) host_vf_reset_set <= 1'b0;
    cycles(3);
    cmp_word("vf_busy_low", 32'h1, vf_busy[31:0]);
    cmp_word("vf_busy_high", 32'h8000_0000, vf_busy[251:220]);
    rd(`SB_REG_IRQ_STATUS, 32'h2, `SB_RESP_OKAY);
    cfg(8'hFF, 1'b0, 8'h00, 1'b1);
    cfg(8'h05, 1'b0, 8'h00, 1'b0);
    wr(`SB_REG_VF_DONE, 32'h03, `SB_RESP_OKAY);
    wr(`SB_REG_VF_DONE, 32'hFF, `SB_RESP_OKAY);
    cycles(3);
    cmp_word("vf_busy_high", 32'h0, vf_busy[251:220]);
    cmp_word("vf_busy_low", 32'h1, vf_busy[31:0]);
    cfg(8'hFF, 1'b0, 8'h00, 1'b0);
    wr(`SB_REG_VF_DONE, 32'h04, `SB_RESP_OKAY);
    cycles(3);
    cmp_word("vf_busy_low", 32'h0, vf_busy[31:0]);
    $display("test virtual reset done");
    wr(`SB_REG_CTRL, 32'h5, `SB_RESP_OKAY);
    cycles(3);
    cmp_word("aer", 32'h5, 32'(aer_internal_error));
    cmp_word("messages", 32'h1, 32'(msg_count));
    aer_status_clear <= 4'h1;
    @(posedge aclk) aer_status_clear <= 4'h0;
    cycles(2);
    cmp_word("aer", 32'h4, 32'(aer_internal_error));
    error_message_enable <= 1'b0;
    wr(`SB_REG_CTRL, 32'h5, `SB_RESP_OKAY);
    cycles(3);
    cmp_word("messages", 32'h1, 32'(msg_count));
    rd(`SB_REG_CTRL, 32'h1, `SB_RESP_OKAY);
    $display("test internal error done");
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
